// ==== verilog/smirb_pkg.sv ====
package smirb_pkg;
	// ***********************************************************
	// Register offsets
	// ***********************************************************
	localparam logic [7:0] OFF_TRIM_LOCK_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONV_RESULT_LOW = 8'h01;
	localparam logic [7:0] OFF_CONV_RESULT_HIGH = 8'h02;
	localparam logic [7:0] OFF_CONV_INPUT_CONTROL = 8'h03;
	localparam logic [7:0] OFF_SIGNATURE_BYTE_0 = 8'h04;
	localparam logic [7:0] OFF_SIGNATURE_BYTE_1 = 8'h05;
	localparam logic [7:0] OFF_SIGNATURE_BYTE_2 = 8'h06;
	localparam logic [7:0] OFF_SIGNATURE_BYTE_3 = 8'h07;
	localparam logic [7:0] OFF_DEVICE_SOFT_RESET = 8'h08;
	localparam logic [7:0] OFF_TRIM_DAC_1 = 8'h09;
	localparam logic [7:0] OFF_TRIM_DAC_2 = 8'h0a;
	localparam logic [7:0] OFF_TRIM_DAC_3 = 8'h0b;
	localparam logic [7:0] OFF_TRIM_DAC_4 = 8'h0c;
	localparam logic [7:0] OFF_TRIM_DAC_5 = 8'h0d;
	localparam logic [7:0] OFF_TRIM_DAC_6 = 8'h0e;
	// ***********************************************************
	// Field positions
	// ***********************************************************
	localparam int ALERT_BIT_POS = 6;
	localparam int RANGE_BIT_POS = 4;
	localparam int DONE_BIT_POS = 0;
	// ***********************************************************
	// Reset values
	// ***********************************************************
	localparam logic RST_ALERT = 1'b1;
	localparam logic [7:0] RST_INPUT_CONTROL = 8'h00;
	localparam logic [7:0] RST_TRIM = 8'h80;
	localparam logic [2:0] LOW_FILL_ONES = 3'h7;
	localparam logic [11:0] RST_RESULT = 12'h000;
	// Select code for the analog supply input
	localparam logic [2:0] SEL_ANALOG_SUPPLY = 3'h6;
	// ***********************************************************
	// Timing
	// ***********************************************************
	localparam int CLK_MHZ = 25;
	localparam int T_CONVERT_US = 100;
	localparam int CONVERT_CYCLES = T_CONVERT_US * CLK_MHZ;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] offset;
		logic [7:0] data;
	} smirb_req_t;

	typedef struct packed {
		logic [11:0] value;
		logic [2:0] input_sel;
		logic range_sel;
	} smirb_conv_t;
endpackage

// ==== verilog/smirb_bank.sv ====
// Contract
// - Six read-only lock bits, one per trim output
// - Lock bit set when supply hits profile zero
// - Logic sets alert bit, waits for host
// - Low/high result layout with done flag
// - Range bit picks 2 mV or 6 mV
// - Three-bit select routes inputs one to six
// - Control write starts a conversion
// - Done low while converting, high when valid
// - Restart defers done until last conversion
// - Signature bytes low byte first, read-only
// - Any write to reset register resets device
// - Six trim registers load and read back
// - Alert bit reads one after reset, suspended
// - Write offset then data; read separately
`timescale 1ns/1ps
module smirb_bank #(
	parameter int CONVERT_CYCLES = smirb_pkg::CONVERT_CYCLES,
	parameter logic [31:0] SIGNATURE = 32'h0000_0000 // Arbitrary value
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire smirb_pkg::smirb_req_t req,
	output logic [7:0] rd_data,
	input wire logic [5:0] lock_in,
	input wire logic alert_mode,
	output logic alert_active,
	output logic soft_reset,
	output logic conv_start,
	output smirb_pkg::smirb_conv_t conv_setup,
	input wire logic conv_ready,
	input wire logic [11:0] conv_value,
	output logic [47:0] trim_dac
);
	localparam int CW = $clog2(CONVERT_CYCLES + 1);
	// Reload and end counts of the conversion timer
	localparam logic [CW-1:0] TIMER_LOAD = CW'(CONVERT_CYCLES);
	localparam logic [CW-1:0] TIMER_LAST = CW'(1);

	typedef enum logic [1:0] {
		SMIRB_IDLE = 2'b01,
		SMIRB_BUSY = 2'b10
	} smirb_state_t;

	// ***********************************************************
	// Decode helpers
	// ***********************************************************
	// One strobe decode for every write path
	function automatic logic is_write(input smirb_pkg::smirb_req_t r,
		input logic [7:0] off);
		is_write = r.wr && (r.offset == off);
	endfunction

	// Alert tracks the all-outputs-locked summary, not each bit
	function automatic logic all_locked(input logic [5:0] v);
		all_locked = &v;
	endfunction

	function automatic logic [7:0] result_low(input logic [11:0] value,
		input logic flag);
		result_low = {value[3:0], smirb_pkg::LOW_FILL_ONES, flag};
	endfunction

	// Only called for mapped trim offsets, so the slot is below six
	function automatic logic [2:0] trim_slot(input logic [7:0] off);
		logic [7:0] diff;
		diff = off - smirb_pkg::OFF_TRIM_DAC_1;
		trim_slot = diff[2:0];
	endfunction

	// ***********************************************************
	// Status and control state
	// ***********************************************************
	logic alert;
	logic next_alert;
	logic [5:0] lock_q;
	logic [5:0] next_lock_q;
	logic [2:0] input_sel;
	logic [2:0] next_input_sel;
	logic range_sel;
	logic next_range_sel;
	logic lock_change;

	// ***********************************************************
	// Conversion state
	// ***********************************************************
	smirb_state_t state;
	smirb_state_t next_state;
	logic [CW-1:0] timer;
	logic [CW-1:0] next_timer;
	logic [11:0] result;
	logic [11:0] next_result;
	logic done;
	logic next_done;
	logic next_conv_start;
	logic ctl_wr;

	// ***********************************************************
	// Trim and bus state
	// ***********************************************************
	logic [7:0] trim [6];
	logic [7:0] next_trim [6];
	logic [7:0] next_rd_data;
	logic next_soft_reset;
	logic rst_wr;

	// ***********************************************************
	// Strobes and decodes
	// ***********************************************************
	assign ctl_wr = is_write(req, smirb_pkg::OFF_CONV_INPUT_CONTROL);
	assign rst_wr = is_write(req, smirb_pkg::OFF_DEVICE_SOFT_RESET);
	assign lock_change = all_locked(lock_q) != all_locked(lock_in);

	always_comb begin
		next_lock_q = lock_in;
		next_alert = alert;
		if (is_write(req, smirb_pkg::OFF_TRIM_LOCK_STATUS)) begin
			// Only the alert bit is writable; lock bits ignore data
			next_alert = req.data[smirb_pkg::ALERT_BIT_POS];
		end
		// Set beats host clear; suspended while bit still high
		if (alert_mode && !alert && lock_change) begin
			next_alert = 1'b1;
		end
		next_input_sel = input_sel;
		next_range_sel = range_sel;
		if (ctl_wr) begin
			next_input_sel = req.data[2:0];
			next_range_sel = req.data[smirb_pkg::RANGE_BIT_POS];
		end
	end

	// ***********************************************************
	// Trim registers
	// ***********************************************************
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			next_trim[i] = trim[i];
			if (is_write(req, smirb_pkg::OFF_TRIM_DAC_1 + 8'(i))) begin
				next_trim[i] = req.data;
			end
		end
	end

	// ***********************************************************
	// Conversion sequencer
	// ***********************************************************
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_result = result;
		next_done = done;
		next_conv_start = 1'b0;
		unique case (state)
			SMIRB_IDLE: begin
				if (ctl_wr) begin
					next_state = SMIRB_BUSY;
					next_done = 1'b0;
					next_timer = TIMER_LOAD;
					next_conv_start = 1'b1;
				end
			end
			SMIRB_BUSY: begin
				if (ctl_wr) begin
					// Restart drops the running result
					next_timer = TIMER_LOAD;
					next_conv_start = 1'b1;
				end else if (timer > TIMER_LAST) begin
					next_timer = timer - TIMER_LAST;
				end else if (conv_ready) begin
					// Waits at the last count for a slow converter
					next_result = conv_value;
					next_done = 1'b1;
					next_state = SMIRB_IDLE;
				end
			end
		endcase
	end

	// ***********************************************************
	// Read mux
	// ***********************************************************
	always_comb begin
		next_soft_reset = rst_wr;
		next_rd_data = rd_data;
		if (req.rd) begin
			unique case (req.offset)
				smirb_pkg::OFF_TRIM_LOCK_STATUS: begin
					// Top bit unused, reads zero
					next_rd_data = {1'b0, alert, lock_q};
				end
				smirb_pkg::OFF_CONV_RESULT_LOW: begin
					next_rd_data = result_low(result, done);
				end
				smirb_pkg::OFF_CONV_RESULT_HIGH: begin
					next_rd_data = result[11:4];
				end
				smirb_pkg::OFF_CONV_INPUT_CONTROL: begin
					next_rd_data = {3'h0, range_sel, 1'b0, input_sel};
				end
				smirb_pkg::OFF_SIGNATURE_BYTE_0,
				smirb_pkg::OFF_SIGNATURE_BYTE_1,
				smirb_pkg::OFF_SIGNATURE_BYTE_2,
				smirb_pkg::OFF_SIGNATURE_BYTE_3: begin
					next_rd_data = SIGNATURE[8*req.offset[1:0] +: 8];
				end
				smirb_pkg::OFF_TRIM_DAC_1,
				smirb_pkg::OFF_TRIM_DAC_2,
				smirb_pkg::OFF_TRIM_DAC_3,
				smirb_pkg::OFF_TRIM_DAC_4,
				smirb_pkg::OFF_TRIM_DAC_5,
				smirb_pkg::OFF_TRIM_DAC_6: begin
					next_rd_data = trim[trim_slot(req.offset)];
				end
				default: begin
					// Reset register is write-only; unmapped reads zero
					next_rd_data = 8'h00;
				end
			endcase
		end
	end

	// ***********************************************************
	// Status and control registers
	// ***********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alert <= smirb_pkg::RST_ALERT;
			lock_q <= 6'h00;
			input_sel <= smirb_pkg::RST_INPUT_CONTROL[2:0];
			range_sel <= smirb_pkg::RST_INPUT_CONTROL[4];
		end else if (clk_en) begin
			if (soft_reset) begin
				// Back to power-on values; alerts suspended again
				alert <= smirb_pkg::RST_ALERT;
				lock_q <= 6'h00;
				input_sel <= smirb_pkg::RST_INPUT_CONTROL[2:0];
				range_sel <= smirb_pkg::RST_INPUT_CONTROL[4];
			end else begin
				alert <= next_alert;
				lock_q <= next_lock_q;
				input_sel <= next_input_sel;
				range_sel <= next_range_sel;
			end
		end
	end

	// ***********************************************************
	// Conversion sequencer registers
	// ***********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= SMIRB_IDLE;
			timer <= '0;
			result <= smirb_pkg::RST_RESULT;
			done <= 1'b1;
			conv_start <= 1'b0;
		end else if (clk_en) begin
			if (soft_reset) begin
				// A running conversion is abandoned
				state <= SMIRB_IDLE;
				timer <= '0;
				result <= smirb_pkg::RST_RESULT;
				done <= 1'b1;
				conv_start <= 1'b0;
			end else begin
				state <= next_state;
				timer <= next_timer;
				result <= next_result;
				done <= next_done;
				conv_start <= next_conv_start;
			end
		end
	end

	// ***********************************************************
	// Trim registers, flops
	// ***********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 6; i++) begin
				trim[i] <= smirb_pkg::RST_TRIM;
			end
		end else if (clk_en) begin
			if (soft_reset) begin
				for (int i = 0; i < 6; i++) begin
					trim[i] <= smirb_pkg::RST_TRIM;
				end
			end else begin
				for (int i = 0; i < 6; i++) begin
					trim[i] <= next_trim[i];
				end
			end
		end
	end

	// ***********************************************************
	// Bus side registers
	// ***********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 8'h00;
			soft_reset <= 1'b0;
		end else if (clk_en) begin
			if (soft_reset) begin
				// Pulse lasts one cycle even if the master writes again
				rd_data <= 8'h00;
				soft_reset <= 1'b0;
			end else begin
				rd_data <= next_rd_data;
				soft_reset <= next_soft_reset;
			end
		end
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	// Pin follows the bit only in alert mode
	assign alert_active = alert_mode && alert;
	assign conv_setup = '{value: result, input_sel: input_sel,
		range_sel: range_sel};
	for (genvar g = 0; g < 6; g++) begin : g_trim_out
		assign trim_dac[8*g +: 8] = trim[g];
	end
endmodule // smirb_bank

// ==== sim/smirb_conv_model.sv ====
`timescale 1ns/1ps
module smirb_conv_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic conv_start,
	input wire smirb_pkg::smirb_conv_t conv_setup,
	output logic conv_ready,
	output logic [11:0] conv_value
);
	logic [2:0] cnt;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 3'h0;
		end else if (conv_start) begin
			cnt <= 3'h5;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
	assign conv_ready = (cnt == 3'h0);
	// Result encodes the setup, so a stale load shows up
	assign conv_value = {5'h1B, conv_setup.range_sel, 3'h0,
		conv_setup.input_sel};
endmodule // smirb_conv_model

// ==== sim/smirb_bank_monitor.sv ====
`timescale 1ns/1ps
module smirb_bank_monitor #(
	parameter int CONVERT_CYCLES = 8,
	parameter logic [31:0] SIGNATURE = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire smirb_pkg::smirb_req_t req,
	input wire logic [7:0] rd_data,
	input wire logic alert_mode,
	input wire logic alert_active,
	input wire logic soft_reset,
	input wire logic conv_start,
	input wire smirb_pkg::smirb_conv_t conv_setup,
	input wire logic [47:0] trim_dac
);
	logic wr_go;
	logic rd_go;
	assign wr_go = clk_en && req.wr;
	assign rd_go = clk_en && req.rd;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_soft_pulse: assert property (wr_go && !soft_reset &&
		req.offset == 8'h08 |=> soft_reset)
		else $error("soft reset pulse missing");
	a_start_pulse: assert property (wr_go && !soft_reset &&
		req.offset == 8'h03 |=> conv_start)
		else $error("conversion start missing");
	a_trim_load: assert property (wr_go && !soft_reset &&
		req.offset == 8'h09 |=> trim_dac[7:0] == $past(req.data))
		else $error("trim load wrong");
	a_trim_hold: assert property (!wr_go && !soft_reset |=> $stable(trim_dac))
		else $error("trim changed unasked");
	a_sig_read: assert property (rd_go && !soft_reset &&
		req.offset == 8'h04 |=> rd_data == SIGNATURE[7:0])
		else $error("signature byte wrong");
	a_low_ones: assert property (rd_go && !soft_reset &&
		req.offset == 8'h01 |=> rd_data[3:1] == 3'h7)
		else $error("result low fill wrong");
	a_alert_rearm: assert property (clk_en && soft_reset |=>
		alert_active == alert_mode) else $error("alert not rearmed");
	a_setup_load: assert property (wr_go && !soft_reset &&
		req.offset == 8'h03 |=>
		conv_setup.input_sel == $past(req.data[2:0]) &&
		conv_setup.range_sel == $past(req.data[4])) else $error("setup wrong");
	a_alert_mode: assert property (!alert_mode |-> !alert_active)
		else $error("alert outside alert mode");
	cover property (conv_start);
	cover property (soft_reset);
	cover property (alert_active);
endmodule // smirb_bank_monitor

bind smirb_bank smirb_bank_monitor #(.CONVERT_CYCLES(CONVERT_CYCLES),
	.SIGNATURE(SIGNATURE)) mon (.clk(clk), .nrst(nrst), .clk_en(clk_en),
	.req(req), .rd_data(rd_data), .alert_mode(alert_mode),
	.alert_active(alert_active), .soft_reset(soft_reset),
	.conv_start(conv_start), .conv_setup(conv_setup), .trim_dac(trim_dac));

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] SIG = 32'hA1B2_C3D4; // Arbitrary value
	logic clk, nrst, clk_en, alert_mode, alert_active, soft_reset;
	logic conv_start, conv_ready;
	logic [5:0] lock_in;
	logic [7:0] rd_data;
	logic [11:0] conv_value;
	logic [47:0] trim_dac;
	smirb_pkg::smirb_req_t req;
	smirb_pkg::smirb_conv_t conv_setup;
	int err_total = 0;
	int checks_done = 0;
	smirb_bank #(.CONVERT_CYCLES(8), .SIGNATURE(SIG)) dut (.clk(clk),
		.nrst(nrst), .clk_en(clk_en), .req(req), .rd_data(rd_data),
		.lock_in(lock_in), .alert_mode(alert_mode),
		.alert_active(alert_active), .soft_reset(soft_reset),
		.conv_start(conv_start), .conv_setup(conv_setup),
		.conv_ready(conv_ready), .conv_value(conv_value),
		.trim_dac(trim_dac));
	smirb_conv_model model (.clk(clk), .nrst(nrst), .conv_start(conv_start),
		.conv_setup(conv_setup), .conv_ready(conv_ready),
		.conv_value(conv_value));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, off, d};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] off, output logic [7:0] d);
		@(posedge clk) req <= '{1'b0, 1'b1, off, 8'h00};
		@(posedge clk) req <= '0;
		#1 d = rd_data;
	endtask
	task automatic rc(input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] d;
		rd(off, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	// ****************************************************
	// Scenarios
	// ****************************************************
	task automatic t_trim;
		for (int i = 0; i < 6; i++) wr(8'h09 + 8'(i), 8'h11 * 8'(i + 1));
		for (int i = 0; i < 6; i++) begin
			rc(8'h09 + 8'(i), 8'h11 * 8'(i + 1));
			chk({8'h00, trim_dac[8*i +: 8]}, {8'h00, 8'h11 * 8'(i + 1)});
		end
		@(posedge clk) clk_en <= 1'b0;
		wr(8'h09, 8'h5A);
		@(posedge clk) clk_en <= 1'b1;
		rc(8'h09, 8'h11);
		wr(8'h04, 8'h00);
		rc(8'h04, SIG[7:0]);
		rc(8'h07, SIG[31:24]);
		rc(8'h0F, 8'h00);
		$display("trim and signature test ended");
	endtask
	task automatic t_conv;
		logic [7:0] d;
		for (int s = 0; s < 7; s++) begin
			wr(8'h03, {3'h7, 1'(s), 1'b1, 3'(s)});
			#1 chk({12'h000, conv_setup.range_sel, conv_setup.input_sel},
				{12'h000, 1'(s), 3'(s)});
		end
		rc(8'h03, 8'h06);
		wr(8'h03, 8'h02);
		rc(8'h01, 8'h0E);
		d = 8'h00;
		for (int n = 0; n < 20 && d[0] !== 1'b1; n++) rd(8'h01, d);
		chk({8'h00, d}, 16'h002F);
		rc(8'h02, 8'hD8);
		wr(8'h03, 8'h13);
		wr(8'h03, 8'h15);
		repeat (12) @(posedge clk);
		rd(8'h01, d);
		rd(8'h02, d);
		rc(8'h01, 8'h5F);
		rc(8'h02, 8'hDC);
		$display("conversion test ended");
	endtask
	task automatic t_alert;
		@(posedge clk) alert_mode <= 1'b1;
		wr(8'h00, 8'h00);
		rc(8'h00, 8'h15);
		@(posedge clk) lock_in <= 6'h3F;
		for (int n = 0; n < 8 && alert_active !== 1'b1; n++) @(posedge clk);
		#1 chk({15'h0000, alert_active}, 16'h0001);
		rc(8'h00, 8'h7F);
		wr(8'h00, 8'h00);
		rc(8'h00, 8'h3F);
		wr(8'h08, 8'h5A);
		repeat (2) @(posedge clk);
		rc(8'h09, 8'h80);
		rc(8'h00, 8'h7F);
		$display("alert and soft reset test ended");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		results;
	end
	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		alert_mode = 1'b0;
		lock_in = 6'h15;
		req = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rc(8'h00, 8'h55);
		rc(8'h01, 8'h0F);
		rc(8'h09, 8'h80);
		$display("reset value test ended");
		t_trim;
		t_conv;
		t_alert;
		results;
	end
endmodule // testbench
